/* hw/eeprom_slave_pkg.sv */
// Constants, field layouts and state encoding for the serial EEPROM target
package eeprom_slave_pkg;

    // Array geometry
    localparam int unsigned ADDR_W     = 13;           // Word address width
    localparam int unsigned PAGE_W     = 5;            // In-page offset bits
    localparam int unsigned DATA_W     = 8;            // Word width
    localparam int unsigned MEM_DEPTH  = 8192;         // Words in the array
    localparam int unsigned HI_ADDR_W  = ADDR_W - 8;   // Bits kept of byte one

    // Device address word layout
    localparam logic [3:0] DEV_TYPE     = 4'ha;        // Fixed 1010 pattern
    localparam int unsigned DEV_TYPE_LSB = 4;          // Type field position
    localparam int unsigned STRAP_LSB    = 1;          // Strap compare field
    localparam int unsigned RW_BIT       = 0;          // 1 = read, 0 = write

    // Protected region: top quarter of the array
    localparam logic [1:0] PROT_TOP     = 2'h3;        // addr[12:11] value

    // Bit counter landmarks within one byte frame
    localparam logic [3:0] BIT_LAST     = 4'h8;        // Eight bits taken
    localparam logic [3:0] BIT_ACK      = 4'h9;        // Ninth clock seen

    // Timing
    localparam int unsigned CLK_HZ        = 50_000_000; // System clock rate
    localparam int unsigned WRITE_TIME_US = 5_000;      // 5 ms write cycle
    localparam int unsigned WR_CYCLES     =
        WRITE_TIME_US * (CLK_HZ / 1_000_000);           // Longest: round down
    localparam int unsigned BUSY_W        = 18;         // Busy counter width

    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000; // Counter at power-up

    // Protocol states, Gray coded along the usual path
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,  // Standby, waiting for a start
        ST_DEVADR = 3'h1,  // Shifting the device address word
        ST_ADRHI  = 3'h3,  // First word-address byte
        ST_ADRLO  = 3'h2,  // Second word-address byte
        ST_WDATA  = 3'h6,  // Write data bytes
        ST_RDATA  = 3'h7   // Read data bytes
    } state_t;

endpackage

/* hw/word_buffer.sv */
// Two-entry valid/ready buffer between the serial front end and the array
`timescale 1ns/1ps
module word_buffer #(
    parameter int unsigned WIDTH = 21                  // Word width
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    logic [WIDTH-1:0] slot_q [2];                      // Storage entries
    logic             rd_ptr_q;                        // Oldest entry
    logic             wr_ptr_q;                        // Next free entry
    logic [1:0]       count_q;                         // Entries held
    logic             push_w;                          // Accepted write
    logic             pop_w;                           // Accepted read

    // Honest full and empty flags
    assign in_ready_o  = (count_q != 2'h2);
    assign out_valid_o = (count_q != 2'h0);
    assign out_data_o  = slot_q[rd_ptr_q];
    assign push_w      = in_valid_i & in_ready_o;
    assign pop_w       = out_valid_o & out_ready_i;

    // Pointers and occupancy
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            if (push_w) wr_ptr_q <= ~wr_ptr_q;
            if (pop_w)  rd_ptr_q <= ~rd_ptr_q;
            count_q <= count_q + {1'b0, push_w} - {1'b0, pop_w};
        end
    end

    // Data store needs no reset
    always_ff @(posedge clk_i) begin
        if (push_w) slot_q[wr_ptr_q] <= in_data_i;
    end

endmodule // word_buffer

/* hw/eeprom_slave.sv */
// Two-wire serial EEPROM target: protocol engine, write timer and array
// Operation
// - SDA fall with SCL high is start
// - SDA rise with SCL high is stop
// - SDA changes while SCL high are conditions
// - Eight-bit words, receiver acks on ninth clock
// - Standby at power-up and after stop
// - Device word top nibble must be 1010
// - Next three bits match chip-select straps
// - Last device word bit selects direction
// - Ack on match, else standby
// - Write protect blocks upper quarter writes
// - Byte write: device, two address, data
// - Self-timed write after stop, inputs ignored
// - Write cycle finishes within 5 ms
// - Page write up to 32 bytes
// - Only low five address bits wrap
// - Ack polling acks only after write done
// - Address counter holds last plus one
// - Read address wraps over whole array
// - Current read sends byte at counter
// - Sequential read continues while controller acks
// - Sample on SCL rise, drive after fall
// - 256 pages of 32, 13-bit address
`timescale 1ns/1ps
module eeprom_slave
    import eeprom_slave_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WR_CYCLES    // Shorten in sims
) (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [2:0] chip_select_straps_i,
    input  wire logic       wp_i,
    output logic            standby_o,
    output logic            write_busy_o
);
    import eeprom_slave_pkg::*;

    localparam int unsigned BUF_W = ADDR_W + DATA_W;   // Address plus data

    // Synchronisers: stage one feeds only stage two
    logic [4:0]  meta_q;                               // First stage
    logic [4:0]  sync_q;                               // Second stage
    logic        scl_p_q;                              // Previous SCL
    logic        sda_p_q;                              // Previous SDA
    logic        scl_s, sda_s;                         // Clean levels
    logic        wp_m_q, wp_q;                         // Protect sync pair
    logic [2:0]  strap_s;                              // Clean straps

    // Protocol state
    state_t              state_q;                      // Protocol state
    logic [3:0]          cnt_q;                        // Clock rises in frame
    logic [7:0]          rx_q;                         // Incoming byte
    logic [7:0]          tx_q;                         // Outgoing byte
    logic                acking_q;                     // Driving our ack
    logic                read_dir_q;                   // Direction latched
    logic                hack_q;                       // Controller acked
    logic [HI_ADDR_W-1:0] hi_q;                        // Upper address part
    logic [ADDR_W-1:0]   addr_q;                       // Address counter
    logic                wr_pend_q;                    // Data taken, no stop
    logic [BUSY_W-1:0]   busy_q;                       // Write cycle timer
    logic                oe_q;                         // Pulls SDA low
    logic                sda_q;                        // Level driven
    logic                standby_q;                    // Standby flag
    logic                busy_flag_q;                  // Registered busy out
    logic [DATA_W-1:0]   mem [MEM_DEPTH];              // Cell array stand-in

    // Decode wires
    logic scl_rise, scl_fall, start_w, stop_w;
    logic busy_w, recv_w, decide_w, end_ack_w;
    logic dev_match_w, do_ack_w, rd_load_w;
    logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
    logic [BUF_W-1:0] buf_out_data;
    logic [ADDR_W-1:0] wr_addr_w;
    logic protect_w, mem_we_w;
    logic [ADDR_W-1:0] page_next_w;

    // Decoding used both by the write path and by the assertions
    function automatic logic in_prot(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: 2] == PROT_TOP;
    endfunction

    // Two flops on every pin before anything looks at it
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= 5'h1f;
            sync_q <= 5'h1f;
        end else begin
            meta_q <= {chip_select_straps_i, sda_i, scl_i};
            sync_q <= meta_q;
        end
    end
    assign scl_s   = sync_q[0];
    assign sda_s   = sync_q[1];
    assign strap_s = sync_q[4:2];
    // Write protect has its own synchroniser pair near the array port

    // Edge history for SCL and SDA
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Bus event decode
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_w  = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_w   = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign busy_w   = (busy_q != '0);

    // Receive states share one frame handler
    assign recv_w    = (state_q == ST_DEVADR) | (state_q == ST_ADRHI) |
                       (state_q == ST_ADRLO) | (state_q == ST_WDATA);
    assign decide_w  = recv_w & scl_fall & (cnt_q == BIT_LAST) & ~acking_q;
    assign end_ack_w = recv_w & scl_fall & (cnt_q == BIT_ACK) & acking_q;

    // Device word compare; a running write cycle hides the part
    assign dev_match_w = (rx_q[7:DEV_TYPE_LSB] == DEV_TYPE) &
                         (rx_q[STRAP_LSB +: 3] == strap_s) &
                         ~busy_w;

    // Ack decision per byte kind; protected data still acked
    assign do_ack_w = (state_q == ST_DEVADR) ? dev_match_w :
                      (state_q == ST_WDATA)  ? buf_in_ready :
                      1'b1;

    // Read byte loads after our device ack or a controller ack
    assign rd_load_w = scl_fall & (cnt_q == BIT_ACK) &
                       (((state_q == ST_DEVADR) & acking_q & read_dir_q) |
                        ((state_q == ST_RDATA) & hack_q));

    // Page wrap keeps the row, moves the low five bits
    assign page_next_w = {addr_q[ADDR_W-1:PAGE_W],
                          addr_q[PAGE_W-1:0] + 5'h01};

    // Write data enters the buffer at its ack decision
    assign buf_in_valid = decide_w & (state_q == ST_WDATA) & buf_in_ready;

    // Protocol engine
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 4'h0;
            rx_q       <= 8'h00;
            tx_q       <= 8'h00;
            acking_q   <= 1'b0;
            read_dir_q <= 1'b0;
            hack_q     <= 1'b0;
            hi_q       <= '0;
            addr_q     <= ADDR_RST;
            wr_pend_q  <= 1'b0;
            oe_q       <= 1'b0;
        end else if (start_w) begin
            // Start or repeated start: fresh device word
            state_q  <= ST_DEVADR;
            cnt_q    <= 4'h0;
            acking_q <= 1'b0;
            oe_q     <= 1'b0;
        end else if (stop_w) begin
            // Stop: release, write data now owes a write cycle
            state_q   <= ST_IDLE;
            acking_q  <= 1'b0;
            oe_q      <= 1'b0;
            wr_pend_q <= 1'b0;
        end else if (scl_rise && recv_w) begin
            // Sample on the rising edge only
            if (cnt_q < BIT_LAST) rx_q <= {rx_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
        end else if (scl_rise && state_q == ST_RDATA) begin
            // Ninth rise carries the controller's answer
            if (cnt_q == BIT_LAST) hack_q <= ~sda_s;
            cnt_q <= cnt_q + 4'h1;
        end else if (decide_w) begin
            // Byte complete: ack or drop out to standby
            if (do_ack_w) begin
                acking_q <= 1'b1;
                oe_q     <= 1'b1;
            end else begin
                state_q <= ST_IDLE;
            end
            case (state_q)
                ST_DEVADR: read_dir_q <= rx_q[RW_BIT];
                ST_ADRHI:  hi_q <= rx_q[HI_ADDR_W-1:0];
                ST_ADRLO:  addr_q <= {hi_q, rx_q};
                ST_WDATA: begin
                    addr_q    <= page_next_w;
                    wr_pend_q <= 1'b1;
                end
                default: ;
            endcase
        end else if (rd_load_w) begin
            // Next byte at the counter, first bit after the fall
            state_q  <= ST_RDATA;
            tx_q     <= mem[addr_q];
            oe_q     <= ~mem[addr_q][7];
            addr_q   <= addr_q + 13'h0001;
            cnt_q    <= 4'h0;
            acking_q <= 1'b0;
            hack_q   <= 1'b0;
        end else if (end_ack_w) begin
            // Ack clock over: release and step to next byte kind
            acking_q <= 1'b0;
            oe_q     <= 1'b0;
            cnt_q    <= 4'h0;
            case (state_q)
                ST_DEVADR: state_q <= ST_ADRHI;
                ST_ADRHI:  state_q <= ST_ADRLO;
                ST_ADRLO:  state_q <= ST_WDATA;
                default:   state_q <= state_q;
            endcase
        end else if (scl_fall && state_q == ST_RDATA) begin
            // Shift out, then free the line for the controller
            if (cnt_q < BIT_LAST) oe_q <= ~tx_q[3'h7 - cnt_q[2:0]];
            else if (cnt_q == BIT_LAST) oe_q <= 1'b0;
            else state_q <= ST_IDLE;
        end
    end

    // Self-timed write cycle, counted from the stop
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) busy_q <= '0;
        else if (stop_w && wr_pend_q && !busy_w)
            busy_q <= BUSY_W'(WRITE_CYCLES);
        else if (busy_w) busy_q <= busy_q - 1'b1;
    end

    // Buffer: array port is shared with read loads, so it can stall
    word_buffer #(
        .WIDTH (BUF_W)
    ) u_buf (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   ({addr_q, rx_q}),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_out_ready),
        .out_data_o  (buf_out_data)
    );
    assign buf_out_ready = ~rd_load_w;
    assign wr_addr_w     = buf_out_data[BUF_W-1:DATA_W];
    assign protect_w     = wp_q & in_prot(wr_addr_w);
    assign mem_we_w      = buf_out_valid & buf_out_ready & ~protect_w;

    // Protect level via its own synchroniser pair
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_m_q <= 1'b0;
            wp_q   <= 1'b0;
        end else begin
            wp_m_q <= wp_i;
            wp_q   <= wp_m_q;
        end
    end

    // Array write; protected words are silently dropped
    always_ff @(posedge clk_i) begin
        if (mem_we_w) mem[wr_addr_w] <= buf_out_data[DATA_W-1:0];
    end

    // Pin and status flops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sda_q       <= 1'b0;
            standby_q   <= 1'b1;
            busy_flag_q <= 1'b0;
        end else begin
            sda_q       <= 1'b0;                                     // Open drain
            busy_flag_q <= busy_w;
            standby_q <= (state_q == ST_IDLE) & ~busy_w &
                         ~buf_out_valid;
        end
    end
    assign sda_o        = sda_q;
    assign sda_oe_o     = oe_q;
    assign standby_o    = standby_q;
    assign write_busy_o = busy_flag_q;

    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    start_to_dev_a: assert property (start_w |=> state_q == ST_DEVADR)
        else $error("start did not open device word");
    stop_to_idle_a: assert property (stop_w |=> state_q == ST_IDLE)
        else $error("stop did not return to idle");
    ack_on_match_a: assert property (
        decide_w && state_q == ST_DEVADR && dev_match_w |=> oe_q && acking_q)
        else $error("matching address not acked");
    busy_no_ack_a: assert property (
        decide_w && state_q == ST_DEVADR && busy_w |=> !oe_q)
        else $error("acked while write cycle runs");
    prot_no_write_a: assert property (
        !(mem_we_w && in_prot(wr_addr_w) && wp_q))
        else $error("protected word written");
    page_row_kept_a: assert property (
        buf_in_valid |=> addr_q[ADDR_W-1:PAGE_W] ==
                         $past(addr_q[ADDR_W-1:PAGE_W]))
        else $error("page row moved during write");
    busy_len_a: assert property (
        $rose(busy_w) |-> busy_q == BUSY_W'(WRITE_CYCLES))
        else $error("write cycle length wrong");
    oe_after_fall_a: assert property (
        $rose(oe_q) |-> $past(scl_fall) || $past(start_w))
        else $error("data driven outside clock low");
    read_step_a: assert property (
        rd_load_w |=> addr_q == $past(addr_q) + 13'h0001)
        else $error("read counter did not advance");

    dev_ack_c: cover property (decide_w && state_q == ST_DEVADR && do_ack_w);
    seq_read_c: cover property (rd_load_w && state_q == ST_RDATA);
    poll_nack_c: cover property (decide_w && state_q == ST_DEVADR && busy_w);
    buf_full_c: cover property (!buf_in_ready);

endmodule // eeprom_slave

/* verif/i2c_ctrl_model.sv */
// Two-wire bus controller model that drives SCL and pulls SDA low
`timescale 1ns/1ps
module i2c_ctrl_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    // Bus idle: SCL parked high, SDA released to its pull-up
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Wait n system clocks; every change lands on a falling edge
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // One bit slot: 100 ns low, 60 ns high, 160 ns in all
    task automatic bit_x(input logic b, output logic r);
        w(2);
        sda_oe_o = ~b;
        w(3);
        scl_o = 1'b1;
        w(3);
        r = sda_i;  // Sampled late in the high phase, settled by then
        scl_o = 1'b0;
    endtask
    // SDA falls while SCL stays high
    task automatic start();
        w(2);
        sda_oe_o = 1'b0;
        w(3);
        scl_o = 1'b1;
        w(3);
        sda_oe_o = 1'b1;
        w(3);
        scl_o = 1'b0;
    endtask
    // SDA rises while SCL stays high
    task automatic stop();
        w(2);
        sda_oe_o = 1'b1;
        w(3);
        scl_o = 1'b1;
        w(3);
        sda_oe_o = 1'b0;
        w(3);
    endtask
    // Nine clocks with SDA released free any half-finished transfer
    task automatic recover();
        logic r;
        scl_o = 1'b0;
        repeat (9) bit_x(1'b1, r);
        w(3);
        scl_o = 1'b1;
    endtask
    // Byte out MSB first; ack is a low ninth bit from the target
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    // Byte in, then ack to go on or withhold to end the read
    task automatic get(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~ack, r);
    endtask
endmodule // i2c_ctrl_model

/* verif/test_eeprom_slave.sv */
// Self-checking bench for the serial EEPROM target
`timescale 1ns/1ps
module test_eeprom_slave;
    import eeprom_slave_pkg::*;
    localparam int unsigned WCYC  = 200;   // Short write cycle for sims
    localparam logic [2:0]  STRAP = 3'h5;  // Board strap setting
    logic       clk_i    = 1'b0;           // 50 MHz system clock
    logic       arst_n_i = 1'b0;           // Held low at start
    logic [2:0] straps   = STRAP;          // Strap pins
    logic       wp       = 1'b0;           // Write protect pin
    logic       dut_oe;                    // Target pulls SDA low
    logic       dut_sda;                   // Target's driven level
    logic       ctl_oe;                    // Controller pulls SDA low
    logic       scl;                       // Bus clock from controller
    logic       stby;                      // Standby flag
    logic       busy;                      // Write cycle flag
    wire        sda = ~((dut_oe & ~dut_sda) | ctl_oe);  // Pull-up bus
    int         fails       = 0;
    int         check_count = 0;
    int         cyc         = 0;           // Free running cycle count
    logic       ack;
    logic [7:0] rd;
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    eeprom_slave #(.WRITE_CYCLES(WCYC)) dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda),
        .sda_o(dut_sda), .sda_oe_o(dut_oe), .chip_select_straps_i(straps),
        .wp_i(wp), .standby_o(stby), .write_busy_o(busy));
    i2c_ctrl_model ctl (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
        .sda_oe_o(ctl_oe));
    // Flag and ack compare
    task automatic chk1(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %b", $time, m, got);
        end
    endtask
    // Data byte compare
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                        input string m);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Device word plus word address; junk fills the unused top bits
    task automatic addr(input logic [12:0] a, input logic [2:0] junk);
        ctl.start();
        ctl.put({DEV_TYPE, STRAP, 1'b0}, ack);
        chk1(ack, 1'b1, "dev ack");
        ctl.put({junk, a[12:8]}, ack);
        chk1(ack, 1'b1, "hi ack");
        ctl.put(a[7:0], ack);
        chk1(ack, 1'b1, "lo ack");
    endtask
    // Wait out the write cycle; strict also polls while it runs
    task automatic settle(input logic strict);
        int t0;
        t0 = cyc;
        ctl.w(4);
        if (strict) begin
            chk1(busy, 1'b1, "busy");
            chk1(stby, 1'b0, "stby busy");
            ctl.start();
            ctl.put({DEV_TYPE, STRAP, 1'b1}, ack);
            chk1(ack, 1'b0, "poll nack");
            ctl.stop();
        end
        while (busy !== 1'b0 && cyc - t0 < WCYC + 20) ctl.w(1);
        chk1(busy, 1'b0, "busy end");
        if (busy !== 1'b0) stop_test();
        ctl.start();
        ctl.put({DEV_TYPE, STRAP, 1'b0}, ack);
        chk1(ack, 1'b1, "poll ack");
        ctl.stop();
    endtask
    // Up to three data bytes, first in the top byte of d
    task automatic wr(input logic [12:0] a, input logic [23:0] d,
                      input int n, input logic strict);
        int k;
        addr(a, 3'h7);
        for (k = 0; k < n; k++) begin
            ctl.put(d[23-8*k -: 8], ack);
            chk1(ack, 1'b1, "data ack");
        end
        ctl.stop();
        settle(strict);
    endtask
    // Read n bytes at the counter, acking all but the last
    task automatic rdn(input int n, input logic [15:0] exp);
        int k;
        ctl.start();
        ctl.put({DEV_TYPE, STRAP, 1'b1}, ack);
        chk1(ack, 1'b1, "rd dev ack");
        for (k = 0; k < n; k++) begin
            ctl.get(k < n - 1, rd);
            chk8(rd, exp[15-8*k -: 8], "rd data");
        end
        ctl.stop();
        ctl.w(4);
        chk1(stby, 1'b1, "stby");
    endtask
    // Main sequence
    initial begin
        repeat (12) @(negedge clk_i);
        arst_n_i = 1'b1;
        chk1(stby, 1'b1, "stby rst");
        ctl.w(4);
        ctl.recover();
        // A wrong type nibble and a wrong strap value both go unanswered
        ctl.start();
        ctl.put({4'hb, STRAP, 1'b0}, ack);
        chk1(ack, 1'b0, "type nack");
        ctl.start();
        ctl.put({DEV_TYPE, 3'h2, 1'b0}, ack);
        chk1(ack, 1'b0, "strap nack");
        ctl.stop();
        $display("Test addressing done");
        wr(13'h0123, 24'h5aa500, 2, 1'b1);
        addr(13'h0123, 3'h0);
        rdn(1, 16'h5a00);
        rdn(1, 16'ha500);
        $display("Test byte write and current read done");
        // Page write crossing the page end wraps to its start
        wr(13'h005e, 24'h112233, 3, 1'b1);
        addr(13'h0040, 3'h0);
        rdn(1, 16'h3300);
        addr(13'h005e, 3'h0);
        rdn(2, 16'h1122);
        $display("Test page wrap done");
        // Reads run from the last byte of the array back to the first
        wr(13'h1fff, 24'hc30000, 1, 1'b1);
        wr(13'h0000, 24'h3c0000, 1, 1'b1);
        addr(13'h1fff, 3'h0);
        rdn(2, 16'hc33c);
        $display("Test read wrap done");
        // Protected quarter keeps its data, the rest still writable
        wr(13'h1800, 24'h110000, 1, 1'b1);
        wp = 1'b1;
        wr(13'h1800, 24'h770000, 1, 1'b0);
        wr(13'h17ff, 24'h220000, 1, 1'b0);
        addr(13'h17ff, 3'h0);
        rdn(2, 16'h2211);
        $display("Test write protect done");
        stop_test();
    end
endmodule // test_eeprom_slave
